// >>> verilog/pwm_cfg.svh
// register offsets, field positions and reset values of the pwm unit
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ------------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------------
`define OFS_INT_STATUS   8'h00
`define OFS_CTRL         8'h04
`define OFS_COUNT        8'h08
`define OFS_PRESCALE     8'h0c
`define OFS_PRESCALE_CNT 8'h10
`define OFS_MATCH_CTL    8'h14
`define OFS_MATCH_BASE   8'h18
`define OFS_MATCH_LAST   8'h30
`define OFS_OUT_CTL      8'h34
`define OFS_RELEASE      8'h38
`define OFS_INT_MASK     8'h3c

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CTRL_COUNT_EN    0
`define CTRL_CLEAR       1
`define CTRL_PWM_EN      3
`define MCTL_WIDTH       3
`define OUT_SEL_LSB      1
`define OUT_EN_LSB       9

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define WORD_RESET       32'h0000_0000
`define FLAGS_RESET      7'h00
`define OUTS_RESET       6'h00
`define ACT_RESET        3'h0

`endif

// >>> verilog/pwm_pkg.sv
// types shared by the pwm unit and its helpers
package pwm_pkg;

    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT   = 6;

    typedef logic [31:0] word_type;

    // action taken when a match register equals the count
    typedef struct packed {
        logic stop;
        logic rst;
        logic irq;
    } match_act_type;

    // apb request as seen by the slave
    typedef struct packed {
        logic [7:0] paddr;
        logic       pwrite;
        word_type   pwdata;
        logic       psel;
        logic       penable;
    } apb_req_type;

endpackage : pwm_pkg

// >>> verilog/prescale_divider.sv
// prescale counter that yields one tick per programmed period
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cfg.svh"

module prescale_divider
    import pwm_pkg::*;
(
    // clock and reset
    input  wire logic     clk,
    input  wire logic     reset,
    // control
    input  wire logic     clear,
    input  wire logic     run,
    input  wire word_type limit,
    // status
    output logic          tick,
    output word_type      count
);

    // tick when the count reaches the limit, then wrap to zero
    assign tick = run && !clear && (count == limit);

    always_ff @(posedge clk)
    begin
        if (reset || clear)
        begin
            count <= `WORD_RESET;
        end
        else if (tick)
        begin
            count <= `WORD_RESET;
        end
        else if (run)
        begin
            count <= count + 32'h0000_0001;
        end
    end

endmodule : prescale_divider
`default_nettype wire

// >>> verilog/pwm_edge_out.sv
// one pwm output stage: set and clear strobes, clear takes priority
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cfg.svh"

module pwm_edge_out
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // control
    input  wire logic enable,
    input  wire logic set_hit,
    input  wire logic clr_hit,
    // pin
    output logic      level
);

    always_ff @(posedge clk)
    begin
        if (reset || !enable)
        begin
            level <= 1'b0;
        end
        else if (clr_hit)
        begin
            // clear wins so a clear match equal to the set match gives constant low
            level <= 1'b0;
        end
        else if (set_hit)
        begin
            level <= 1'b1;
        end
    end

endmodule : pwm_edge_out
`default_nettype wire

// >>> verilog/match_based_pwm_unit.sv
// pwm unit: prescaled timer, seven match registers, apb slave
// ------------------------------------------------------------------
// What this block does
// - timer counts prescaler ticks, compared against seven match registers
// - cycle match register resets the count in pwm mode, setting period
// - single-edge output falls on its own match register
// - single-edge outputs rise at cycle start unless constantly low
// - double-edge output set by one match, cleared by next match
// - up to six single-edge, three double-edge, or a mix
// - each match may keep running, stop or reset, plus interrupt
// - period and width are any number of timer counts
// - in pwm mode, new match values apply only after release, at cycle start
// - without pwm mode the unit acts as a plain timer
// - 32-bit counter behind a programmable 32-bit prescaler
// - all match interrupts merge onto one interrupt line
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cfg.svh"

module match_based_pwm_unit
    import pwm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // pwm pins, index 1 to 6
    output logic [6:1]       pwm_out
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // index of the match register at addr, or 7 when none
    function automatic logic [2:0] match_sel(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - `OFS_MATCH_BASE;
        if (addr >= `OFS_MATCH_BASE && addr <= `OFS_MATCH_LAST &&
            rel[1:0] == 2'b00)
        begin
            match_sel = rel[4:2];
        end
        else
        begin
            match_sel = 3'h7;
        end
    endfunction : match_sel

    function automatic logic is_mapped(input logic [7:0] addr);
        case (addr)
            `OFS_INT_STATUS, `OFS_CTRL, `OFS_COUNT, `OFS_PRESCALE,
            `OFS_PRESCALE_CNT, `OFS_MATCH_CTL, `OFS_OUT_CTL,
            `OFS_RELEASE, `OFS_INT_MASK:
                is_mapped = 1'b1;
            default:
                is_mapped = (match_sel(addr) != 3'h7);
        endcase
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    apb_req_type            req;
    logic                   count_en_r;
    logic                   clear_r;
    logic                   pwm_en_r;
    word_type               prescale_r;
    word_type               count_r;
    word_type               pre_count;
    logic                   tick;
    match_act_type [6:0]    act_r;
    word_type               buf_r [NUM_MATCH];
    word_type               shadow_r [NUM_MATCH];
    logic [6:0]             release_r;
    logic [6:0]             status_r;
    logic [6:0]             mask_r;
    logic [6:1]             double_r;
    logic [6:1]             out_en_r;
    logic [31:0]            prdata_r;
    logic [31:0]            rd_nxt;
    logic [6:0]             match_hit;
    logic [6:0]             rst_vec;
    logic [6:0]             stop_vec;
    logic [6:0]             irq_vec;
    logic                   reset_hit;
    logic                   stop_hit;
    logic                   cycle_start;
    logic                   access;
    logic                   wr;
    logic [2:0]             wsel;

    // ------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------
    assign req.paddr   = paddr;
    assign req.pwrite  = pwrite;
    assign req.pwdata  = pwdata;
    assign req.psel    = psel;
    assign req.penable = penable;

    assign access  = req.psel && req.penable;
    assign pready  = 1'b1;
    assign pslverr = access && !is_mapped(req.paddr);
    assign wr      = access && req.pwrite && is_mapped(req.paddr);
    assign wsel    = match_sel(req.paddr);
    assign prdata  = prdata_r;

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    prescale_divider u_prescale
    (
        .clk   (clk),
        .reset (reset),
        .clear (clear_r),
        .run   (count_en_r),
        .limit (prescale_r),
        .tick  (tick),
        .count (pre_count)
    );

    // ------------------------------------------------------------------
    // match compare and actions
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_MATCH; i++)
        begin
            match_hit[i] = tick && (count_r == shadow_r[i]);
            rst_vec[i]   = act_r[i].rst;
            stop_vec[i]  = act_r[i].stop;
            irq_vec[i]   = act_r[i].irq;
        end
        // in pwm mode the cycle match always restarts the period
        rst_vec[0] = act_r[0].rst || pwm_en_r;
    end

    assign reset_hit   = |(match_hit & rst_vec);
    assign stop_hit    = |(match_hit & stop_vec);
    assign cycle_start = pwm_en_r && match_hit[0];

    // ------------------------------------------------------------------
    // timer counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset || clear_r)
        begin
            count_r <= `WORD_RESET;
        end
        else if (tick)
        begin
            if (reset_hit)
            begin
                count_r <= `WORD_RESET;
            end
            else
            begin
                count_r <= count_r + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_en_r <= 1'b0;
            clear_r    <= 1'b0;
            pwm_en_r   <= 1'b0;
        end
        else
        begin
            if (wr && req.paddr == `OFS_CTRL)
            begin
                clear_r  <= req.pwdata[`CTRL_CLEAR];
                pwm_en_r <= req.pwdata[`CTRL_PWM_EN];
            end
            // a stop match in the same cycle beats a software write
            if (stop_hit)
            begin
                count_en_r <= 1'b0;
            end
            else if (wr && req.paddr == `OFS_CTRL)
            begin
                count_en_r <= req.pwdata[`CTRL_COUNT_EN];
            end
        end
    end

    // ------------------------------------------------------------------
    // prescale value and match actions
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prescale_r <= `WORD_RESET;
        end
        else if (wr && req.paddr == `OFS_PRESCALE)
        begin
            prescale_r <= req.pwdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                act_r[i] <= `ACT_RESET;
            end
        end
        else if (wr && req.paddr == `OFS_MATCH_CTL)
        begin
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                act_r[i] <= match_act_type'(
                    req.pwdata[`MCTL_WIDTH*i +: `MCTL_WIDTH]);
            end
        end
    end

    // ------------------------------------------------------------------
    // match buffers, release flags and active copies
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                buf_r[i] <= `WORD_RESET;
            end
        end
        else if (wr && wsel != 3'h7)
        begin
            buf_r[wsel] <= req.pwdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            release_r <= `FLAGS_RESET;
        end
        else
        begin
            // software release wins over the clear at cycle start
            release_r <= (release_r & ~(cycle_start ? 7'h7f : 7'h00)) |
                         ((wr && req.paddr == `OFS_RELEASE) ?
                          req.pwdata[6:0] : 7'h00);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                shadow_r[i] <= `WORD_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_MATCH; i++)
            begin
                if (!pwm_en_r)
                begin
                    // plain timer: writes act at once
                    shadow_r[i] <= buf_r[i];
                end
                else if (cycle_start && release_r[i])
                begin
                    shadow_r[i] <= buf_r[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // output configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            double_r <= `OUTS_RESET;
            out_en_r <= `OUTS_RESET;
        end
        else if (wr && req.paddr == `OFS_OUT_CTL)
        begin
            // output 1 has no preceding edge match, always single-edge
            double_r <= {req.pwdata[`OUT_SEL_LSB+5 -: 5], 1'b0};
            out_en_r <= req.pwdata[`OUT_EN_LSB+5 -: 6];
        end
    end

    // ------------------------------------------------------------------
    // pwm output stages
    // ------------------------------------------------------------------
    for (genvar n = 1; n <= NUM_OUT; n++)
    begin : g_out
        logic set_hit;
        // single-edge rises on the cycle match, double-edge on match n-1
        assign set_hit = double_r[n] ? match_hit[n-1]
                                     : match_hit[0];

        pwm_edge_out u_edge
        (
            .clk     (clk),
            .reset   (reset),
            .enable  (out_en_r[n] && pwm_en_r),
            .set_hit (set_hit),
            .clr_hit (match_hit[n]),
            .level   (pwm_out[n])
        );
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            status_r <= `FLAGS_RESET;
        end
        else
        begin
            // a new match beats a write-one clear in the same cycle
            status_r <= (status_r &
                         ~((wr && req.paddr == `OFS_INT_STATUS) ?
                           req.pwdata[6:0] : 7'h00)) |
                        (match_hit & irq_vec);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mask_r <= `FLAGS_RESET;
        end
        else if (wr && req.paddr == `OFS_INT_MASK)
        begin
            mask_r <= req.pwdata[6:0];
        end
    end

    // single combined line toward the interrupt controller
    assign irq = |(status_r & mask_r);

    // ------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_nxt = `WORD_RESET;
        case (req.paddr)
            `OFS_INT_STATUS:   rd_nxt = {25'h0, status_r};
            `OFS_CTRL:         rd_nxt = {28'h0, pwm_en_r, 1'b0,
                                         clear_r, count_en_r};
            `OFS_COUNT:        rd_nxt = count_r;
            `OFS_PRESCALE:     rd_nxt = prescale_r;
            `OFS_PRESCALE_CNT: rd_nxt = pre_count;
            `OFS_MATCH_CTL:    rd_nxt = {11'h0, act_r};
            `OFS_OUT_CTL:      rd_nxt = {17'h0, out_en_r, 2'b00,
                                         double_r[6:2], 2'b00};
            `OFS_RELEASE:      rd_nxt = {25'h0, release_r};
            `OFS_INT_MASK:     rd_nxt = {25'h0, mask_r};
            default:
            begin
                if (wsel != 3'h7)
                begin
                    rd_nxt = buf_r[wsel];
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prdata_r <= `WORD_RESET;
        end
        else if (req.psel && !req.penable && !req.pwrite)
        begin
            prdata_r <= rd_nxt;
        end
    end

endmodule : match_based_pwm_unit
`default_nettype wire

// >>> test/pwm_unit_monitor.sv
// concurrent checks on the pwm unit ports
`timescale 1ns/1ps
`default_nettype none

module pwm_unit_monitor
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // outputs
    input  wire logic        irq,
    input  wire logic [6:1]  pwm_out
);
    default clocking cb @(posedge clk);
    endclocking

    // ------------------------------------------------------------
    // bus
    // ------------------------------------------------------------
    sequence s_bad_rd;
        psel && !penable && !pwrite && paddr > 8'h3c ##1 psel && penable;
    endsequence
    sequence s_pwm_off_wr;
        psel && penable && pwrite && paddr == 8'h04 && !pwdata[3];
    endsequence
    sequence s_out_off_wr;
        psel && penable && pwrite && paddr == 8'h34 && pwdata[14:9] == 6'h00;
    endsequence

    property p_ready;
        disable iff (reset) pready;
    endproperty
    property p_err_access;
        disable iff (reset) pslverr |-> psel && penable;
    endproperty
    property p_err_unmapped;
        disable iff (reset)
        psel && penable && (paddr > 8'h3c || paddr[1:0] != 2'b00) |-> pslverr;
    endproperty
    property p_err_mapped;
        disable iff (reset)
        psel && penable && paddr <= 8'h3c && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    property p_bad_read;
        disable iff (reset) s_bad_rd |-> prdata == 32'h0;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_err_access: assert property (p_err_access) else $error("stray err");
    a_err_unmapped: assert property (p_err_unmapped) else $error("no err");
    a_err_mapped: assert property (p_err_mapped) else $error("false err");
    a_bad_read: assert property (p_bad_read) else $error("bad rdata");

    // ------------------------------------------------------------
    // interrupt and pins
    // ------------------------------------------------------------
    property p_mask_off;
        disable iff (reset)
        psel && penable && pwrite && paddr == 8'h3c && pwdata[6:0] == 7'h00
        |=> !irq;
    endproperty
    property p_reset_quiet;
        disable iff (reset) $fell(reset) |-> !irq && pwm_out == 6'h00;
    endproperty
    property p_pwm_off;
        disable iff (reset) s_pwm_off_wr |-> ##[1:2] pwm_out == 6'h00;
    endproperty
    property p_out_off;
        disable iff (reset) s_out_off_wr |-> ##[1:2] pwm_out == 6'h00;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq masked");
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset");
    a_pwm_off: assert property (p_pwm_off) else $error("pins in timer");
    a_out_off: assert property (p_out_off) else $error("pin enable");
endmodule : pwm_unit_monitor

bind match_based_pwm_unit pwm_unit_monitor u_mon (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .pwm_out(pwm_out));

`default_nettype wire

// >>> test/pwm_load_model.sv
// loads on the pwm pins: high cycles and rising edges
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model
(
    // clock
    input  wire logic       clk,
    // control
    input  wire logic       clr,
    input  wire logic       meas,
    // pins
    input  wire logic [6:1] pwm_out,
    // results
    output logic [15:0]     high_cnt [1:6],
    output logic [15:0]     rise_cnt [1:6]
);
    logic [6:1] last_r;

    // duty and rate seen in clock counts
    always_ff @(posedge clk)
    begin
        last_r <= pwm_out;
        for (int n = 1; n <= 6; n++)
        begin
            if (clr)
            begin
                high_cnt[n] <= 16'h0;
                rise_cnt[n] <= 16'h0;
            end
            else if (meas)
            begin
                high_cnt[n] <= high_cnt[n] + 16'(pwm_out[n]);
                rise_cnt[n] <= rise_cnt[n] + 16'(pwm_out[n] & !last_r[n]);
            end
        end
    end
endmodule : pwm_load_model

`default_nettype wire

// >>> test/match_based_pwm_unit_test.sv
// self-checking bench of the pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "pwm_cfg.svh"

module match_based_pwm_unit_test;
    import pwm_pkg::*;

    logic        clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    word_type    pwdata;
    word_type    prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [6:1]  pwm_out;
    logic        clr;
    logic        meas;
    logic [15:0] high_cnt [1:6];
    logic [15:0] rise_cnt [1:6];
    word_type    rd;
    word_type    c1;
    logic        er;
    int          n0;
    int          n2;
    int          bad_count;
    int          compares;

    match_based_pwm_unit DUT (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .pwm_out(pwm_out));
    pwm_load_model u_load (.clk(clk), .clr(clr), .meas(meas),
        .pwm_out(pwm_out), .high_cnt(high_cnt), .rise_cnt(rise_cnt));

    always #12.5 clk = ~clk;
    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic check_word(input word_type got, input word_type exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t word got %h exp %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t bit got %b exp %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic apb(input logic w, input logic [7:0] a, input word_type d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        check_bit(pready, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input word_type d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input word_type exp);
        apb(1'b0, a, 32'h0);
        check_word(rd, exp);
    endtask : rdchk

    task automatic chk_irq(input logic exp);
        @(negedge clk);
        check_bit(irq, exp);
    endtask : chk_irq

    task automatic measure();
        repeat (30) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr  <= 1'b0;
        meas <= 1'b1;
        repeat (50) @(posedge clk);
        meas <= 1'b0;
        @(posedge clk);
    endtask : measure

    task automatic pin(input int n, input int hi, input int ri);
        check_word({16'h0, high_cnt[n]}, word_type'(hi));
        check_word({16'h0, rise_cnt[n]}, word_type'(ri));
    endtask : pin

    task automatic time_irq(input word_type ps, output int n);
        wr(`OFS_CTRL, 32'h0000_0002);
        wr(`OFS_PRESCALE, ps);
        wr(`OFS_CTRL, 32'h0000_0001);
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
    endtask : time_irq

    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        results();
    end

    initial
    begin
        clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; clr = 1'b0;
        meas = 1'b0; bad_count = 0; compares = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        check_bit(irq, 1'b0);
        check_word({26'h0, pwm_out}, 32'h0);
        for (int a = 0; a <= `OFS_INT_MASK; a += 4)
            rdchk(a[7:0], `WORD_RESET);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b0, (k == 0) ? 8'h40 : 8'h02, 32'h0);
            check_bit(er, 1'b1);
            check_word(rd, 32'h0);
        end
        wr(`OFS_COUNT, 32'h0000_0055);
        rdchk(`OFS_COUNT, 32'h0);
        wr(`OFS_PRESCALE, 32'hffff_ffff);
        rdchk(`OFS_PRESCALE, 32'hffff_ffff);
        $display("test reset done");

        wr(`OFS_MATCH_BASE + 8'h04, 32'h0000_0005);
        wr(`OFS_MATCH_CTL, 32'h0000_0028);
        wr(`OFS_INT_MASK, 32'h0000_0002);
        time_irq(32'h0, n0);
        wr(`OFS_INT_STATUS, 32'h0000_0002);
        time_irq(32'h2, n2);
        check_bit(n0 < 300, 1'b1);
        check_word(word_type'(n2 - n0), 32'd12);
        rdchk(`OFS_CTRL, 32'h0);
        apb(1'b0, `OFS_COUNT, 32'h0);
        c1 = rd;
        repeat (5) @(posedge clk);
        rdchk(`OFS_COUNT, c1);
        chk_irq(1'b1);
        rdchk(`OFS_INT_STATUS, 32'h0000_0002);
        wr(`OFS_INT_MASK, 32'h0);
        chk_irq(1'b0);
        wr(`OFS_INT_MASK, 32'h0000_0002);
        chk_irq(1'b1);
        wr(`OFS_INT_STATUS, 32'h0000_0002);
        chk_irq(1'b0);
        rdchk(`OFS_INT_STATUS, 32'h0);
        wr(`OFS_CTRL, 32'h0000_0002);
        wr(`OFS_MATCH_CTL, 32'h0000_0010);
        wr(`OFS_PRESCALE, 32'h0);
        wr(`OFS_CTRL, 32'h0000_0001);
        repeat (8)
        begin
            apb(1'b0, `OFS_COUNT, 32'h0);
            check_bit(rd < 32'd6, 1'b1);
        end
        check_word({26'h0, pwm_out}, 32'h0);
        $display("test timer done");

        wr(`OFS_CTRL, 32'h0000_0002);
        wr(`OFS_MATCH_CTL, 32'h0);
        wr(`OFS_MATCH_BASE, 32'h0000_0009);
        for (int n = 1; n <= 6; n++)
            wr(`OFS_MATCH_BASE + 8'(4 * n), word_type'(n));
        wr(`OFS_OUT_CTL, 32'h0000_7e00);
        wr(`OFS_RELEASE, 32'h0000_007f);
        wr(`OFS_CTRL, 32'h0000_0009);
        measure();
        for (int n = 1; n <= 6; n++)
            pin(n, 5 * (n + 1), 5);
        wr(`OFS_MATCH_BASE + 8'h04, 32'h0000_0006);
        measure();
        pin(1, 10, 5);
        wr(`OFS_RELEASE, 32'h0000_0002);
        measure();
        pin(1, 35, 5);
        wr(`OFS_OUT_CTL, 32'h0000_7e04);
        rdchk(`OFS_OUT_CTL, 32'h0000_7e04);
        measure();
        pin(2, 30, 5);
        wr(`OFS_MATCH_BASE + 8'h08, 32'h0000_0008);
        wr(`OFS_RELEASE, 32'h0000_0004);
        measure();
        pin(2, 10, 5);
        wr(`OFS_MATCH_BASE + 8'h04, 32'h0000_0009);
        wr(`OFS_RELEASE, 32'h0000_0002);
        measure();
        pin(1, 0, 0);
        wr(`OFS_OUT_CTL, 32'h0);
        repeat (3) @(posedge clk);
        check_word({26'h0, pwm_out}, 32'h0);
        wr(`OFS_OUT_CTL, 32'h0000_7e00);
        wr(`OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check_word({26'h0, pwm_out}, 32'h0);
        $display("test pwm done");
        results();
    end
endmodule : match_based_pwm_unit_test

`default_nettype wire
